// ### rtl/wevb_pkg.sv
// wire event bridge constants, register map and encodings
package wevb_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int NUM_WIRES = 32;
	localparam int IDX_W     = 5;
	localparam int ADDR_W    = 8;
	localparam int EVNUM_W   = 16;
	localparam int SRC_W     = 16;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] BRIDGE_CONTROL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] WIRE_ENABLE_OFS    = 8'h04;
	localparam logic [ADDR_W-1:0] WIRE_TRIGGER_OFS   = 8'h08;
	localparam logic [ADDR_W-1:0] WIRE_EN_STATUS_OFS = 8'h0c;
	localparam logic [ADDR_W-1:0] BRIDGE_ID_OFS      = 8'h10;
	localparam logic [ADDR_W-1:0] SOURCE_ID_OFS      = 8'h14;

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int GLOBAL_ENABLE_BIT = 0;
	localparam int GLOBAL_IDLE_BIT   = 1;
	localparam int WIRE_EN_IDLE_BIT  = 0;
	localparam int WIRE_RANGE_LSB    = 0;
	localparam int WIRE_RANGE_W      = 11;
	localparam logic [WIRE_RANGE_W-1:0] WIRE_RANGE_VAL = 11'h000;
	localparam logic [NUM_WIRES-1:0]    WIRE_ENABLE_RST  = 32'h0000_0000;
	localparam logic [NUM_WIRES-1:0]    WIRE_TRIGGER_RST = 32'h0000_0000;

	// value is arbitrary, must be unique in the translation service
	localparam logic [SRC_W-1:0] SOURCE_ID = 16'h0a5c;

	// ------------------------------------------------------------
	// event types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		WEVB_EV_EDGE_SET  = 2'h0,
		WEVB_EV_LEVEL_SET = 2'h1,
		WEVB_EV_RELEASE   = 2'h2
	} wevb_event_e;

	// ------------------------------------------------------------
	// global enable sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		WEVB_OFF,
		WEVB_TURN_ON,
		WEVB_ON_DRAIN,
		WEVB_ON,
		WEVB_OFF_DRAIN
	} wevb_state_e;

endpackage : wevb_pkg

// ### rtl/wevb_sync.sv
// two-stage synchroniser for the interrupt wire inputs
`timescale 1ns/1ps

module wevb_sync #(
	parameter int W = 32
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	// asynchronous input and synchronised output
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);

	// ------------------------------------------------------------
	// two flops per bit, first one read only by the second
	// ------------------------------------------------------------
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			meta_q  <= '0;
			syncOut <= '0;
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end

endmodule : wevb_sync

// ### rtl/wevb_bridge.sv
// wire event bridge: wired interrupts to translation service events
`timescale 1ns/1ps

module wevb_bridge (
	// clock and reset
	input  wire logic                          clk_sys,
	input  wire logic                          rstn,
	// apb slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [wevb_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// interrupt wires
	input  wire logic [wevb_pkg::NUM_WIRES-1:0] wireIn,
	// event stream to the translation service
	output logic                               evValid,
	input  wire logic                          evReady,
	output logic      [1:0]                    evType,
	output logic      [wevb_pkg::SRC_W-1:0]    evSource,
	output logic      [wevb_pkg::EVNUM_W-1:0]  evNumber
);

	localparam int NW = wevb_pkg::NUM_WIRES;

	typedef struct packed {
		wevb_pkg::wevb_state_e       st;
		logic                        enBit;
		logic [NW-1:0]               wen;
		logic [NW-1:0]               tm;
		logic [NW-1:0]               prevLvl;
		logic [NW-1:0]               edgePend;
		logic [NW-1:0]               sentLvl;
		logic [NW-1:0]               forceRep;
		logic [wevb_pkg::IDX_W-1:0]  ptr;
		logic                        evValid;
		logic [1:0]                  evType;
		logic [wevb_pkg::IDX_W-1:0]  evNum;
		logic [31:0]                 rdata;
	} wevb_regs_s;

	wevb_regs_s s_q;
	wevb_regs_s s_d;

	// ------------------------------------------------------------
	// input synchronisation
	// ------------------------------------------------------------
	logic [NW-1:0] lvl;

	wevb_sync #(
		.W (NW)
	) u_sync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.asyncIn (wireIn),
		.syncOut (lvl)
	);

	// ------------------------------------------------------------
	// per-wire event demand
	// ------------------------------------------------------------
	logic          glbOn;
	logic [NW-1:0] activeLvl;
	logic [NW-1:0] activeEdge;
	logic [NW-1:0] rise;
	logic [NW-1:0] lvlNeed;
	logic [NW-1:0] edgeNeed;
	logic [NW-1:0] relNeed;
	logic          outFree;
	logic          ptrHit;
	logic          loadEv;
	logic [1:0]    loadType;
	logic          glbIdle;
	logic          wenIdle;

	// level demand only while globally on
	assign glbOn      = (s_q.st == wevb_pkg::WEVB_ON_DRAIN) || (s_q.st == wevb_pkg::WEVB_ON);
	assign activeLvl  = {NW{glbOn}} & s_q.wen & s_q.tm;
	assign activeEdge = {NW{glbOn}} & s_q.wen & ~s_q.tm;
	assign rise       = lvl & ~s_q.prevLvl;
	// a level wire owes an event when its reported state differs from the wire;
	// a short pulse that returns before sending leaves no difference
	assign relNeed    = s_q.sentLvl & ~activeLvl;
	assign lvlNeed    = (activeLvl & (s_q.forceRep | (lvl ^ s_q.sentLvl))) | relNeed;
	assign edgeNeed   = activeEdge & s_q.edgePend;
	assign outFree    = !s_q.evValid || evReady;
	assign ptrHit     = lvlNeed[s_q.ptr] || edgeNeed[s_q.ptr];
	assign loadEv     = outFree && ptrHit;

	always_comb begin
		loadType = 2'(wevb_pkg::WEVB_EV_EDGE_SET);
		if (lvlNeed[s_q.ptr]) begin
			if (activeLvl[s_q.ptr] && lvl[s_q.ptr]) begin
				loadType = 2'(wevb_pkg::WEVB_EV_LEVEL_SET);
			end else begin
				loadType = 2'(wevb_pkg::WEVB_EV_RELEASE);
			end
		end
	end

	// idle only when the sequencer settled on the written value
	assign glbIdle = ((s_q.st == wevb_pkg::WEVB_ON) && s_q.enBit) ||
			((s_q.st == wevb_pkg::WEVB_OFF) && !s_q.enBit);
	assign wenIdle = !(|relNeed) && !s_q.evValid;

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	logic apbSetup;
	logic apbWrite;
	logic addrHit;

	assign apbSetup = psel && !penable;
	assign apbWrite = psel && penable && pwrite;
	assign addrHit  = (paddr == wevb_pkg::BRIDGE_CONTROL_OFS) ||
			(paddr == wevb_pkg::WIRE_ENABLE_OFS) ||
			(paddr == wevb_pkg::WIRE_TRIGGER_OFS) ||
			(paddr == wevb_pkg::WIRE_EN_STATUS_OFS) ||
			(paddr == wevb_pkg::BRIDGE_ID_OFS) ||
			(paddr == wevb_pkg::SOURCE_ID_OFS);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [NW-1:0] edgeKeep;
		logic [NW-1:0] forceKeep;
		edgeKeep  = s_q.edgePend & ~s_q.tm;
		forceKeep = s_q.forceRep & s_q.wen & s_q.tm;
		s_d         = s_q;
		s_d.prevLvl = lvl;

		// event output stage, one event held until accepted
		if (s_q.evValid && evReady) begin
			s_d.evValid = 1'b0;
		end
		if (loadEv) begin
			s_d.evValid = 1'b1;
			s_d.evType  = loadType;
			s_d.evNum   = s_q.ptr;
			if (lvlNeed[s_q.ptr]) begin
				s_d.sentLvl[s_q.ptr] = (loadType == 2'(wevb_pkg::WEVB_EV_LEVEL_SET));
				forceKeep[s_q.ptr]   = 1'b0;
			end else begin
				edgeKeep[s_q.ptr] = 1'b0;
			end
		end
		// round-robin scan bounds the wait for any wire
		if (!(ptrHit && !outFree)) begin
			s_d.ptr = s_q.ptr + 1'b1;
		end
		// a new edge in the clearing cycle survives; latched even when off
		s_d.edgePend = edgeKeep | (rise & ~s_q.tm);
		s_d.forceRep = forceKeep;

		// global enable sequencer
		unique case (s_q.st)
			wevb_pkg::WEVB_OFF: begin
				// pending wire-enable status does not hold off the sequencer
				if (s_q.enBit) begin
					s_d.st = wevb_pkg::WEVB_TURN_ON;
				end
			end
			wevb_pkg::WEVB_TURN_ON: begin
				s_d.forceRep = s_q.wen & s_q.tm;
				s_d.st    = wevb_pkg::WEVB_ON_DRAIN;
			end
			wevb_pkg::WEVB_ON_DRAIN: begin
				if (!(|s_q.forceRep) && !s_q.evValid) begin
					s_d.st = wevb_pkg::WEVB_ON;
				end
			end
			wevb_pkg::WEVB_ON: begin
				if (!s_q.enBit) begin
					s_d.st = wevb_pkg::WEVB_OFF_DRAIN;
				end
			end
			wevb_pkg::WEVB_OFF_DRAIN: begin
				// wire changes are ignored here; only releases drain
				// no domain registers, so every owed release still drains
				if (!(|s_q.sentLvl) && !s_q.evValid) begin
					s_d.st = wevb_pkg::WEVB_OFF;
				end
			end
		endcase

		// register writes; the enable bit touches nothing else
		if (apbWrite) begin
			unique case (paddr)
				wevb_pkg::BRIDGE_CONTROL_OFS: s_d.enBit = pwdata[wevb_pkg::GLOBAL_ENABLE_BIT];
				wevb_pkg::WIRE_ENABLE_OFS:    s_d.wen   = pwdata;
				wevb_pkg::WIRE_TRIGGER_OFS:   s_d.tm    = pwdata;
				default: ;
			endcase
		end

		// read data captured in the setup cycle
		if (apbSetup) begin
			s_d.rdata = 32'h0000_0000;
			unique case (paddr)
				wevb_pkg::BRIDGE_CONTROL_OFS: begin
					s_d.rdata[wevb_pkg::GLOBAL_ENABLE_BIT] = s_q.enBit;
					s_d.rdata[wevb_pkg::GLOBAL_IDLE_BIT]   = glbIdle;
				end
				wevb_pkg::WIRE_ENABLE_OFS:    s_d.rdata = s_q.wen;
				wevb_pkg::WIRE_TRIGGER_OFS:   s_d.rdata = s_q.tm;
				wevb_pkg::WIRE_EN_STATUS_OFS: s_d.rdata[wevb_pkg::WIRE_EN_IDLE_BIT] = wenIdle;
				wevb_pkg::BRIDGE_ID_OFS: begin
					s_d.rdata[wevb_pkg::WIRE_RANGE_LSB +: wevb_pkg::WIRE_RANGE_W] =
						wevb_pkg::WIRE_RANGE_VAL;
				end
				wevb_pkg::SOURCE_ID_OFS: s_d.rdata[wevb_pkg::SRC_W-1:0] = wevb_pkg::SOURCE_ID;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s_q          <= '0;
			s_q.st       <= wevb_pkg::WEVB_OFF;
			s_q.wen      <= wevb_pkg::WIRE_ENABLE_RST;
			s_q.tm       <= wevb_pkg::WIRE_TRIGGER_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata   = s_q.rdata;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !addrHit;
	assign evValid  = s_q.evValid;
	assign evType   = s_q.evType;
	assign evSource = wevb_pkg::SOURCE_ID;
	assign evNumber = {{(wevb_pkg::EVNUM_W - wevb_pkg::IDX_W){1'b0}}, s_q.evNum};

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	logic [5:0] waitCnt_q;

	always_ff @(posedge clk_sys) begin
		if (!rstn || !(|(lvlNeed | edgeNeed)) || !outFree || loadEv) begin
			waitCnt_q <= 6'h00;
		end else begin
			waitCnt_q <= waitCnt_q + 6'h01;
		end
	end

	property p_source_fixed;
		evValid |-> evSource == wevb_pkg::SOURCE_ID;
	endproperty
	a_source_fixed: assert property (p_source_fixed) else $error("source id changed");

	property p_number_is_wire;
		loadEv |=> evValid && evNumber == {11'h000, $past(s_q.ptr)};
	endproperty
	a_number_is_wire: assert property (p_number_is_wire) else $error("wrong event number");

	property p_edge_latched;
		|(rise & ~s_q.tm) |=>
			(s_q.edgePend & $past(rise & ~s_q.tm)) == $past(rise & ~s_q.tm);
	endproperty
	a_edge_latched: assert property (p_edge_latched) else $error("edge lost");

	property p_disabled_wire;
		loadEv && loadType != 2'(wevb_pkg::WEVB_EV_RELEASE) |-> s_q.wen[s_q.ptr];
	endproperty
	a_disabled_wire: assert property (p_disabled_wire) else $error("event from off wire");

	property p_off_silent;
		s_q.st == wevb_pkg::WEVB_OFF |-> !evValid && !loadEv;
	endproperty
	a_off_silent: assert property (p_off_silent) else $error("event while disabled");

	property p_enable_not_idle;
		apbWrite && paddr == wevb_pkg::BRIDGE_CONTROL_OFS && pwdata[0] &&
			s_q.st == wevb_pkg::WEVB_OFF && !s_q.enBit |=> !glbIdle ##1 !glbIdle;
	endproperty
	a_enable_not_idle: assert property (p_enable_not_idle) else $error("idle too early");

	property p_enable_levels;
		s_q.st == wevb_pkg::WEVB_TURN_ON |=> s_q.forceRep == $past(s_q.wen & s_q.tm);
	endproperty
	a_enable_levels: assert property (p_enable_levels) else $error("levels not reported");

	property p_disable_drained;
		$past(s_q.st == wevb_pkg::WEVB_OFF_DRAIN) && s_q.st == wevb_pkg::WEVB_OFF |->
			s_q.sentLvl == '0 && !evValid;
	endproperty
	a_disable_drained: assert property (p_disable_drained) else $error("release outstanding");

	property p_bounded_wait;
		waitCnt_q <= 6'd32;
	endproperty
	a_bounded_wait: assert property (p_bounded_wait) else $error("event postponed");

	property p_hold_until_taken;
		evValid && !evReady |=> evValid && $stable(evType) && $stable(evNumber);
	endproperty
	a_hold_until_taken: assert property (p_hold_until_taken) else $error("event dropped");

	property p_enable_keeps_regs;
		apbWrite && paddr == wevb_pkg::BRIDGE_CONTROL_OFS |=>
			$stable(s_q.wen) && $stable(s_q.tm);
	endproperty
	a_enable_keeps_regs: assert property (p_enable_keeps_regs) else $error("registers disturbed");

	c_edge_event:  cover property (evValid && evReady && evType == 2'(wevb_pkg::WEVB_EV_EDGE_SET));
	c_level_set:   cover property (evValid && evReady && evType == 2'(wevb_pkg::WEVB_EV_LEVEL_SET));
	c_release:     cover property (evValid && evReady && evType == 2'(wevb_pkg::WEVB_EV_RELEASE));
	c_disable_end: cover property (s_q.st == wevb_pkg::WEVB_OFF_DRAIN ##1 s_q.st == wevb_pkg::WEVB_OFF);

endmodule : wevb_bridge

// ### verification/wevb_service_model.sv
// translation service model: accepts bridge events, promptly or with stalls
`timescale 1ns/1ps

module wevb_service_model (
	// clock and reset
	input  wire logic                         clk_sys,
	input  wire logic                         rstn,
	// event stream
	input  wire logic                         evValid,
	output logic                              evReady,
	input  wire logic [1:0]                   evType,
	input  wire logic [wevb_pkg::SRC_W-1:0]   evSource,
	input  wire logic [wevb_pkg::EVNUM_W-1:0] evNumber,
	// bench control and log
	input  wire logic                         slow,
	output int                                accCount,
	output logic      [1:0]                   lastType,
	output logic      [wevb_pkg::SRC_W-1:0]   lastSource,
	output logic      [wevb_pkg::EVNUM_W-1:0] lastNumber
);
	logic [1:0] stallQ;

	// slow mode offers ready one cycle in four
	always @(posedge clk_sys) begin
		if (!rstn) begin
			stallQ   <= 2'h0;
			evReady  <= 1'b0;
			accCount <= 0;
		end else begin
			stallQ  <= stallQ + 2'h1;
			evReady <= !slow || (stallQ == 2'h2);
			if (evValid && evReady) begin
				accCount   <= accCount + 1;
				lastType   <= evType;
				lastSource <= evSource;
				lastNumber <= evNumber;
			end
		end
	end
endmodule : wevb_service_model

// ### verification/testbench.sv
// self-checking bench for the wire event bridge
`timescale 1ns/1ps

module testbench;
	logic        clk_sys = 1'b0;
	logic        rstn, psel, penable, pwrite, evReady, evValid, pready, pslverr, slow;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [31:0] wireIn;
	logic [1:0]  evType, lastType;
	logic [15:0] evSource, evNumber, lastSource, lastNumber;
	logic        rerr;
	int          accCount, seen, err_count, samples_checked;

	always #2.5 clk_sys = ~clk_sys;

	wevb_bridge i_dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wireIn(wireIn), .evValid(evValid), .evReady(evReady),
		.evType(evType), .evSource(evSource), .evNumber(evNumber));

	wevb_service_model i_svc (.clk_sys(clk_sys), .rstn(rstn), .evValid(evValid),
		.evReady(evReady), .evType(evType), .evSource(evSource), .evNumber(evNumber),
		.slow(slow), .accCount(accCount), .lastType(lastType), .lastSource(lastSource),
		.lastNumber(lastNumber));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string name);
		apb(1'b0, a, 32'h0);
		chk(name, e, rdat);
	endtask : rd

	task automatic waitIdle;
		int n;
		n = 0;
		do begin
			apb(1'b0, 8'h00, 32'h0);
			n++;
		end while (rdat[1] !== 1'b1 && n < 100);
		chk("global idle", 32'h1, {31'h0, rdat[1]});
	endtask : waitIdle

	task automatic pulse(input int i, input logic v, input int len);
		@(posedge clk_sys);
		wireIn[i] <= v;
		repeat (len) @(posedge clk_sys);
	endtask : pulse

	task automatic expectEvent(input logic [1:0] t, input logic [15:0] num);
		int n;
		n = 0;
		while (accCount == seen && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		chk("event count", seen + 1, accCount);
		chk("event type", {30'h0, t}, {30'h0, lastType});
		chk("event number", {16'h0, num}, {16'h0, lastNumber});
		chk("event source", {16'h0, wevb_pkg::SOURCE_ID}, {16'h0, lastSource});
		seen = accCount;
	endtask : expectEvent

	task automatic quiet(input int len);
		repeat (len) @(posedge clk_sys);
		chk("no event", seen, accCount);
	endtask : quiet

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		rd(8'h00, 32'h2, "control");
		rd(8'h04, 32'h0, "wire enable");
		rd(8'h08, 32'h0, "trigger mode");
		rd(8'h0c, 32'h1, "enable status");
		rd(8'h10, 32'h0, "wire range");
		apb(1'b1, 8'h14, 32'hffff_ffff);
		rd(8'h14, {16'h0, wevb_pkg::SOURCE_ID}, "source id");
		chk("mapped error", 32'h0, {31'h0, rerr});
		rd(8'h18, 32'h0, "unmapped data");
		chk("unmapped error", 32'h1, {31'h0, rerr});
	endtask : t_reset

	task automatic t_bringup;
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h00, 32'h1);
		waitIdle();
		rd(8'h00, 32'h3, "control on");
		quiet(40);
	endtask : t_bringup

	task automatic t_edge;
		apb(1'b1, 8'h04, 32'h20);
		pulse(5, 1'b1, 4);
		pulse(5, 1'b0, 1);
		expectEvent(wevb_pkg::WEVB_EV_EDGE_SET, 16'h5);
		pulse(5, 1'b1, 4);
		pulse(5, 1'b0, 1);
		expectEvent(wevb_pkg::WEVB_EV_EDGE_SET, 16'h5);
		pulse(9, 1'b1, 40);
		pulse(9, 1'b0, 40);
		quiet(20);
		apb(1'b1, 8'h04, 32'h220);
		expectEvent(wevb_pkg::WEVB_EV_EDGE_SET, 16'h9);
	endtask : t_edge

	task automatic t_level;
		slow <= 1'b1;
		apb(1'b1, 8'h08, 32'h80);
		apb(1'b1, 8'h04, 32'ha0);
		quiet(60);
		pulse(7, 1'b1, 1);
		expectEvent(wevb_pkg::WEVB_EV_LEVEL_SET, 16'h7);
		pulse(7, 1'b0, 1);
		expectEvent(wevb_pkg::WEVB_EV_RELEASE, 16'h7);
		pulse(7, 1'b1, 1);
		expectEvent(wevb_pkg::WEVB_EV_LEVEL_SET, 16'h7);
	endtask : t_level

	task automatic t_disable;
		apb(1'b1, 8'h00, 32'h0);
		waitIdle();
		chk("released at idle", seen + 1, accCount);
		expectEvent(wevb_pkg::WEVB_EV_RELEASE, 16'h7);
		rd(8'h04, 32'ha0, "enable kept");
		rd(8'h08, 32'h80, "trigger kept");
		pulse(7, 1'b0, 40);
		pulse(7, 1'b1, 40);
		quiet(20);
		apb(1'b1, 8'h00, 32'h1);
		waitIdle();
		chk("forced at idle", seen + 1, accCount);
		expectEvent(wevb_pkg::WEVB_EV_LEVEL_SET, 16'h7);
		quiet(40);
	endtask : t_disable

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		rstn    = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		wireIn  = 32'h0;
		slow    = 1'b0;
		seen    = 0;
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset();
		t_bringup();
		t_edge();
		t_level();
		t_disable();
		conclude();
	end

	initial begin
		#100000;
		err_count++;
		conclude();
	end
endmodule : testbench
